// ### rtl/twc_pkg.sv
// Purpose: Constants and carrier types for the two-wire configuration target port
// Assumes: sys_clk at 25 MHz from the crystal reference
// Notes: Holds the summary of operation and every shared number
// Summary of operation
// - Answer to 7-bit address 100110x; lowest bit follows the address strap input.
// - Direction bit 1 requests a read, 0 requests a write.
// - Idle bus has both serial lines high.
// - Ignore everything until a START: data falls while clock is high.
// - Acknowledge own address only; stay released for other addresses.
// - Transaction ends on STOP (data rises, clock high) or repeated START.
// - First written byte after address loads the register address pointer.
// - Pointer increments after each data byte written or read.
// - Serial clock deglitched three reference periods; write bits latch on filtered rise.
// - Read data changes only after the filtered falling clock edge.
// - Only host drives clock; data line is open drain, pulled low or released.
package twc_pkg;
    localparam logic [5:0] DEV_ADDR_HI = 6'h26;
    localparam int FILTER_CYCLES = 3;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] FILT_RESET = 3'h7;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RECV = 5'h02,
        ST_ACK = 5'h04,
        ST_SEND = 5'h08,
        ST_RACK = 5'h10
    } twc_state_e;

    typedef struct packed {
        logic wrStrobe;
        logic [7:0] regAddr;
        logic [7:0] wrData;
    } twc_regwr_s;

    typedef struct packed {
        logic sclRise;
        logic sclFall;
        logic startSeen;
        logic stopSeen;
        logic sclLevel;
        logic sdaLevel;
    } twc_line_s;
endpackage

// ### rtl/twc_sync.sv
// Purpose: Two flip-flop synchroniser for one pin
// Assumes: Input asynchronous to sys_clk
// Notes: Reset value chosen high to match an idle bus
`timescale 1ns/1ns
`default_nettype none
module twc_sync (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic pinIn,
    output logic syncOut
);
    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;

    always_comb begin
        meta_d = pinIn;
        sync_d = meta_q;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign syncOut = sync_q;
endmodule
`default_nettype wire

// ### rtl/twc_filter.sv
// Purpose: Deglitch for the serial clock line, edge detect for the clock and data lines
// Assumes: Inputs already synchronised to sys_clk
// Notes: A clock level change is accepted only after it holds for FILTER_CYCLES clocks; data is not filtered
`timescale 1ns/1ns
`default_nettype none
module twc_filter #(
    parameter int HOLD = twc_pkg::FILTER_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic sclSync,
    input wire logic sdaSync,
    output twc_pkg::twc_line_s line
);
    // Shift history for the clock, held for HOLD samples; data is taken unfiltered so
    // data edges settle before clock edges are qualified
    logic [HOLD-1:0] sclHist_q;
    logic [HOLD-1:0] sclHist_d;
    logic sclLvl_q;
    logic sclLvl_d;
    logic sdaLvl_q;
    logic sdaLvl_d;
    twc_pkg::twc_line_s line_q;
    twc_pkg::twc_line_s line_d;

    always_comb begin
        sclHist_d = {sclHist_q[HOLD-2:0], sclSync};
        sclLvl_d = sclLvl_q;
        if (&sclHist_q) begin
            sclLvl_d = 1'b1;
        end else if (~|sclHist_q) begin
            sclLvl_d = 1'b0;
        end
        sdaLvl_d = sdaSync;
        line_d.sclRise = sclLvl_d & ~sclLvl_q;
        line_d.sclFall = ~sclLvl_d & sclLvl_q;
        // Data edges while the filtered clock stays high
        line_d.startSeen = sclLvl_q & sclLvl_d & sdaLvl_q & ~sdaLvl_d;
        line_d.stopSeen = sclLvl_q & sclLvl_d & ~sdaLvl_q & sdaLvl_d;
        line_d.sclLevel = sclLvl_d;
        line_d.sdaLevel = sdaLvl_d;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sclHist_q <= '1;
            sclLvl_q <= 1'b1;
            sdaLvl_q <= 1'b1;
            line_q <= '0;
        end else begin
            sclHist_q <= sclHist_d;
            sclLvl_q <= sclLvl_d;
            sdaLvl_q <= sdaLvl_d;
            line_q <= line_d;
        end
    end

    assign line = line_q;
endmodule
`default_nettype wire

// ### rtl/twc_target.sv
// Purpose: Two-wire serial target giving a host access to the configuration registers
// Assumes: sys_clk is the 25 MHz crystal reference; scl and sda are raw pins
// Notes: Register file is outside; pointer, write strobe and read data connect to it
`timescale 1ns/1ns
`default_nettype none
module twc_target (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe_n,
    input wire logic addrStrap,
    output twc_pkg::twc_regwr_s regWr,
    output logic [7:0] regPtr,
    output logic rdStrobe,
    input wire logic [7:0] rdData,
    output logic busy
);
    // ********************
    // Pin synchronisers
    // ********************
    logic sclSync;
    logic sdaSync;
    logic strapSync;
    twc_pkg::twc_line_s line;

    twc_sync uSyncScl (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pinIn(sclIn),
        .syncOut(sclSync)
    );

    twc_sync uSyncSda (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pinIn(sdaIn),
        .syncOut(sdaSync)
    );

    twc_sync uSyncStrap (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pinIn(addrStrap),
        .syncOut(strapSync)
    );

    twc_filter #(
        .HOLD(twc_pkg::FILTER_CYCLES)
    ) uFilter (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .sclSync(sclSync),
        .sdaSync(sdaSync),
        .line(line)
    );

    // ********************
    // Byte engine
    // ********************
    twc_pkg::twc_state_e state_q;
    twc_pkg::twc_state_e state_d;
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic [2:0] bitCnt_q;
    logic [2:0] bitCnt_d;
    logic addrPhase_q;
    logic addrPhase_d;
    logic ptrPhase_q;
    logic ptrPhase_d;
    logic readDir_q;
    logic readDir_d;
    logic ackDrive_q;
    logic ackDrive_d;
    logic [7:0] ptr_q;
    logic [7:0] ptr_d;
    logic [7:0] txByte_q;
    logic [7:0] txByte_d;
    logic sdaLow_q;
    logic sdaLow_d;
    twc_pkg::twc_regwr_s wr_q;
    twc_pkg::twc_regwr_s wr_d;
    logic rdStb_q;
    logic rdStb_d;
    logic busy_q;
    logic busy_d;
    logic [7:0] rxByte;
    logic addrHit;

    always_comb begin
        rxByte = {shift_q[6:0], line.sdaLevel};
        addrHit = (rxByte[7:2] == twc_pkg::DEV_ADDR_HI) && (rxByte[1] == strapSync);
        state_d = state_q;
        shift_d = shift_q;
        bitCnt_d = bitCnt_q;
        addrPhase_d = addrPhase_q;
        ptrPhase_d = ptrPhase_q;
        readDir_d = readDir_q;
        ackDrive_d = ackDrive_q;
        ptr_d = ptr_q;
        txByte_d = txByte_q;
        sdaLow_d = sdaLow_q;
        wr_d = wr_q;
        wr_d.wrStrobe = 1'b0;
        rdStb_d = 1'b0;
        busy_d = busy_q;
        if (line.startSeen) begin
            // Start and repeated start both restart address reception
            state_d = twc_pkg::ST_RECV;
            bitCnt_d = twc_pkg::BIT_FIRST;
            addrPhase_d = 1'b1;
            sdaLow_d = 1'b0;
            busy_d = 1'b1;
        end else if (line.stopSeen) begin
            state_d = twc_pkg::ST_IDLE;
            sdaLow_d = 1'b0;
            busy_d = 1'b0;
        end else begin
            unique case (state_q)
                twc_pkg::ST_IDLE: begin
                    sdaLow_d = 1'b0;
                end
                twc_pkg::ST_RECV: begin
                    if (line.sclRise) begin
                        shift_d = rxByte;
                        bitCnt_d = bitCnt_q + 3'h1;
                        if (bitCnt_q == twc_pkg::BIT_LAST) begin
                            state_d = twc_pkg::ST_ACK;
                            ackDrive_d = 1'b1;
                            if (addrPhase_q) begin
                                ackDrive_d = addrHit;
                                readDir_d = rxByte[0];
                                ptrPhase_d = ~rxByte[0];
                                addrPhase_d = 1'b0;
                            end else if (ptrPhase_q) begin
                                ptr_d = rxByte;
                                ptrPhase_d = 1'b0;
                            end else begin
                                wr_d.wrStrobe = 1'b1;
                                wr_d.regAddr = ptr_q;
                                wr_d.wrData = rxByte;
                                ptr_d = ptr_q + 8'h01;
                            end
                        end
                    end
                end
                twc_pkg::ST_ACK: begin
                    if (line.sclFall) begin
                        if (sdaLow_q) begin
                            // Ack window over: release or start sending
                            sdaLow_d = 1'b0;
                            bitCnt_d = twc_pkg::BIT_FIRST;
                            if (readDir_q) begin
                                state_d = twc_pkg::ST_SEND;
                                txByte_d = {rdData[6:0], 1'b0};
                                sdaLow_d = ~rdData[7];
                                rdStb_d = 1'b1;
                                ptr_d = ptr_q + 8'h01;
                            end else begin
                                state_d = twc_pkg::ST_RECV;
                            end
                        end else if (ackDrive_q) begin
                            sdaLow_d = 1'b1;
                        end else begin
                            state_d = twc_pkg::ST_IDLE;
                            busy_d = 1'b0;
                        end
                    end
                end
                twc_pkg::ST_SEND: begin
                    if (line.sclFall) begin
                        if (bitCnt_q == twc_pkg::BIT_LAST) begin
                            state_d = twc_pkg::ST_RACK;
                            sdaLow_d = 1'b0;
                        end else begin
                            sdaLow_d = ~txByte_q[7];
                            txByte_d = {txByte_q[6:0], 1'b0};
                            bitCnt_d = bitCnt_q + 3'h1;
                        end
                    end
                end
                twc_pkg::ST_RACK: begin
                    if (line.sclRise) begin
                        // Host ack means one more byte; no ack means stop sending
                        ackDrive_d = ~line.sdaLevel;
                    end
                    if (line.sclFall) begin
                        bitCnt_d = twc_pkg::BIT_FIRST;
                        if (ackDrive_q) begin
                            state_d = twc_pkg::ST_SEND;
                            txByte_d = {rdData[6:0], 1'b0};
                            sdaLow_d = ~rdData[7];
                            rdStb_d = 1'b1;
                            ptr_d = ptr_q + 8'h01;
                        end else begin
                            state_d = twc_pkg::ST_IDLE;
                            busy_d = 1'b0;
                        end
                    end
                end
                default: begin
                    state_d = twc_pkg::ST_IDLE;
                    sdaLow_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_q <= twc_pkg::ST_IDLE;
            shift_q <= 8'h00;
            bitCnt_q <= twc_pkg::BIT_FIRST;
            addrPhase_q <= 1'b0;
            ptrPhase_q <= 1'b0;
            readDir_q <= 1'b0;
            ackDrive_q <= 1'b0;
            ptr_q <= twc_pkg::PTR_RESET;
            txByte_q <= 8'h00;
            sdaLow_q <= 1'b0;
            wr_q <= '0;
            rdStb_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            shift_q <= shift_d;
            bitCnt_q <= bitCnt_d;
            addrPhase_q <= addrPhase_d;
            ptrPhase_q <= ptrPhase_d;
            readDir_q <= readDir_d;
            ackDrive_q <= ackDrive_d;
            ptr_q <= ptr_d;
            txByte_q <= txByte_d;
            sdaLow_q <= sdaLow_d;
            wr_q <= wr_d;
            rdStb_q <= rdStb_d;
            busy_q <= busy_d;
        end
    end

    // ********************
    // Outputs
    // ********************
    // Open drain: only ever a low level, enable low while pulling
    assign sdaOut = 1'b0;
    assign sdaOe_n = ~sdaLow_q;
    assign regWr = wr_q;
    assign regPtr = ptr_q;
    assign rdStrobe = rdStb_q;
    assign busy = busy_q;
endmodule
`default_nettype wire

// ### test/twc_target_asserts.sv
// Purpose: Checker for the two-wire target port pins
// Assumes: Host keeps clock phases at least 8 sys_clk long
// Notes: Bound to twc_target from the bench top
`timescale 1ns/1ns
`default_nettype none
module twc_target_asserts (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe_n,
    input wire logic addrStrap,
    input wire twc_pkg::twc_regwr_s regWr,
    input wire logic [7:0] regPtr,
    input wire logic rdStrobe,
    input wire logic [7:0] rdData,
    input wire logic busy
);
    // ****
    // Properties
    // ****
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence sStartCond;
        sclIn && !sdaIn;
    endsequence
    sequence sAckHold;
        !sdaOe_n [*8];
    endsequence
    a_data_zero: assert property (sdaOut == 1'b0)
        else $error("data value not low");
    a_idle_release: assert property (!busy && !$past(busy) |-> sdaOe_n)
        else $error("data driven while idle");
    a_start_cause: assert property ($rose(busy) |-> sStartCond)
        else $error("busy without start");
    a_ack_holds: assert property ($fell(sdaOe_n) |-> sAckHold)
        else $error("drive too short");
    a_edge_late: assert property ($changed(sdaOe_n) |-> !sclIn && !$past(sclIn, 4))
        else $error("data changed off clock fall");
    a_wr_ptr_step: assert property (regWr.wrStrobe |-> regPtr == regWr.regAddr + 8'h01)
        else $error("pointer not stepped on write");
    a_wr_on_rise: assert property (regWr.wrStrobe |-> sclIn && $past(sclIn, 4) && busy)
        else $error("write not after clock rise");
    a_rd_ptr_step: assert property (rdStrobe |-> (regPtr == $past(regPtr) + 8'h01)
        or (##1 regPtr == $past(regPtr) + 8'h01))
        else $error("pointer not stepped on read");
endmodule
`default_nettype wire

// ### test/twc_host.sv
// Purpose: Host master model for the two-wire bus
// Assumes: Time step is 4 sys_clk; bits are 20 sys_clk long
// Notes: Data released as 1, the pull-up makes it high
`timescale 1ns/1ns
`default_nettype none
module twc_host (
    input wire logic sys_clk,
    input wire logic sdaLine,
    output logic scl,
    output logic sdaRel
);
    // ****
    // Bus actions
    // ****
    initial begin
        scl = 1'b1;
        sdaRel = 1'b1;
    end
    task automatic q(input int n);
        repeat (n * 4) @(negedge sys_clk);
    endtask
    // Waits first so the slow filtered clock is low before data moves
    task automatic start();
        q(2);
        sdaRel = 1'b1;
        q(1);
        scl = 1'b1;
        q(2);
        sdaRel = 1'b0;
        q(2);
        scl = 1'b0;
    endtask
    task automatic stop();
        q(2);
        sdaRel = 1'b0;
        q(2);
        scl = 1'b1;
        q(2);
        sdaRel = 1'b1;
        q(2);
    endtask
    task automatic bitx(input logic b, output logic r);
        q(2);
        sdaRel = b;
        q(1);
        scl = 1'b1;
        q(1);
        r = sdaLine;
        q(1);
        scl = 1'b0;
    endtask
    // Address byte carries direction in bit 0; ackIn low asks for more
    task automatic xfer(input logic [7:0] tx, input logic ackIn,
                        output logic [7:0] rx, output logic ackOut);
        for (int i = 7; i >= 0; i--) bitx(tx[i], rx[i]);
        bitx(ackIn, ackOut);
    endtask
endmodule
`default_nettype wire

// ### test/testbench.sv
// Purpose: Self-checking bench for the two-wire target port
// Assumes: Register file modelled as pointer xor 5a
// Notes: Clock phases kept at 8 sys_clk or more for the filter delay; data leads the clock rise by 4
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic addrStrap = 1'b0;
    logic [7:0] rdData;
    logic [7:0] regPtr;
    logic [7:0] rx;
    logic scl, sdaRel, sdaLine, sdaOut, sdaOe_n, rdStrobe, busy, ack;
    twc_pkg::twc_regwr_s regWr;
    int fail_count = 0;
    int comparisons = 0;
    logic [15:0] wrLog[$];
    // ****
    // Harness
    // ****
    always #20 sys_clk = ~sys_clk;
    assign sdaLine = sdaRel & (sdaOe_n | sdaOut);
    assign rdData = regPtr ^ 8'h5a;
    int rdCount = 0;
    // Sampled on the falling edge, away from the edge that launches the strobes
    always @(negedge sys_clk) if (regWr.wrStrobe) wrLog.push_back({regWr.regAddr, regWr.wrData});
    always @(negedge sys_clk) if (rdStrobe === 1'b1) rdCount++;
    twc_target dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .sclIn(scl), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .addrStrap(addrStrap), .regWr(regWr),
        .regPtr(regPtr), .rdStrobe(rdStrobe), .rdData(rdData), .busy(busy));
    twc_host host_u (.sys_clk(sys_clk), .sdaLine(sdaLine), .scl(scl), .sdaRel(sdaRel));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out();
        if (fail_count == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // ****
    // Scenarios
    // ****
    // Clocked bits with no START, then the strap picks which address answers
    task automatic t_foreign();
        host_u.scl = 1'b0;
        for (int i = 0; i < 4; i++) host_u.bitx(i[0], ack);
        chk("busy", 16'h0000, {15'h0, busy});
        host_u.start();
        host_u.xfer(8'h9a, 1'b1, rx, ack);
        chk("ack", 16'h0001, {15'h0, ack});
        host_u.stop();
        chk("busy", 16'h0000, {15'h0, busy});
        host_u.start();
        host_u.xfer(8'h98, 1'b1, rx, ack);
        chk("ack", 16'h0000, {15'h0, ack});
        host_u.stop();
    endtask
    task automatic t_write();
        logic [7:0] seq[4] = '{8'h9a, 8'h20, 8'ha5, 8'h3c};
        addrStrap = 1'b1;
        repeat (8) @(negedge sys_clk);
        wrLog.delete();
        host_u.start();
        foreach (seq[i]) begin
            host_u.xfer(seq[i], 1'b1, rx, ack);
            chk("ack", 16'h0000, {15'h0, ack});
        end
        host_u.stop();
        chk("log", 16'h0002, 16'(wrLog.size()));
        chk("log", 16'h20a5, wrLog[0]);
        chk("log", 16'h213c, wrLog[1]);
        chk("ptr", 16'h0022, {8'h00, regPtr});
    endtask
    // Pointer set by a write, then repeated START turns to reading
    task automatic t_read();
        wrLog.delete();
        rdCount = 0;
        host_u.start();
        host_u.xfer(8'h9a, 1'b1, rx, ack);
        host_u.xfer(8'h40, 1'b1, rx, ack);
        chk("ack", 16'h0000, {15'h0, ack});
        host_u.start();
        host_u.xfer(8'h9b, 1'b1, rx, ack);
        chk("ack", 16'h0000, {15'h0, ack});
        for (int i = 0; i < 3; i++) begin
            host_u.xfer(8'hff, i == 2, rx, ack);
            chk("data", {8'h00, (8'h40 + 8'(i)) ^ 8'h5a}, {8'h00, rx});
        end
        host_u.stop();
        chk("ptr", 16'h0043, {8'h00, regPtr});
        chk("log", 16'h0000, 16'(wrLog.size()));
        chk("rdStrobe", 16'h0003, 16'(rdCount));
        chk("busy", 16'h0000, {15'h0, busy});
    endtask
    initial begin
        repeat (2) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (8) @(negedge sys_clk);
        t_foreign();
        t_write();
        t_read();
        close_out();
    end
    initial begin
        #400000;
        fail_count++;
        close_out();
    end
endmodule
bind twc_target twc_target_asserts chk_u (.sys_clk(sys_clk), .rst_n(rst_n), .sclIn(sclIn),
    .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .addrStrap(addrStrap), .regWr(regWr),
    .regPtr(regPtr), .rdStrobe(rdStrobe), .rdData(rdData), .busy(busy));
`default_nettype wire
